/* File: inc/udis_pkg.sv */
// Package for the USB device interrupt status block.
// Assumes a single 10 MHz system clock and a 16-bit parallel CPU bus.
package udis_pkg;
  localparam logic [7:0] UDIS_ADDR_STATUS_MAIN = 8'h18;
  localparam int UDIS_BIT_VBUS_CHG = 15;
  localparam int UDIS_BIT_RESUME = 14;
  localparam int UDIS_BIT_FRAME = 13;
  localparam int UDIS_BIT_DSTATE = 12;
  localparam int UDIS_BIT_CSTAGE = 11;
  localparam int UDIS_BIT_EMPTY = 10;
  localparam int UDIS_BIT_NACK = 9;
  localparam int UDIS_BIT_READY = 8;
  localparam int UDIS_BIT_VBUS_LVL = 7;
  localparam int UDIS_DS_LSB = 4;
  localparam int UDIS_BIT_SETUP = 3;
  localparam int UDIS_CS_LSB = 0;
  localparam int UDIS_FIELD_W = 3;
  localparam int UDIS_NUM_EP = 6;
  localparam logic [15:0] UDIS_RESET_VALUE = 16'h0000;

  typedef enum logic [2:0] {
    UDIS_DS_POWERED = 3'h0,
    UDIS_DS_DEFAULT = 3'h1,
    UDIS_DS_ADDRESS = 3'h2,
    UDIS_DS_CONFIGURED = 3'h3,
    UDIS_DS_SUSPENDED = 3'h4
  } udis_dstate_e;

  localparam logic [2:0] UDIS_CS_SEQ_ERR = 3'h6;

  // Hardware events from the device control unit and SIE, one-cycle pulses
  typedef struct packed {
    logic usb_reset;
    logic suspend;
    logic set_address_done;
    logic set_config_done;
    logic setup_end;
    logic wr_status_entry;
    logic rd_status_entry;
    logic xfer_complete;
    logic seq_error;
    logic frame_start;
    logic setup_rx;
    logic stage_load;
    logic [2:0] stage_code;
  } udis_events_s;

  // Interrupt enable register zero bits, owned outside this block
  typedef struct packed {
    logic vbus_ie;
    logic resume_irq_enable;
    logic frame_ie;
    logic dstate_ie;
    logic cstage_ie;
    logic empty_ie;
    logic nack_ie;
    logic ready_ie;
    logic en_usb_reset;
    logic en_set_address;
    logic en_set_config;
    logic en_suspend;
    logic en_wr_status;
    logic en_rd_status;
    logic en_complete;
    logic en_seq_error;
  } udis_enables_s;
endpackage

/* File: hdl/udis_status.sv */
// Main interrupt status register of a USB device controller.
// Assumes endpoint status and enable registers live outside and
// that vbus and line-state pins are asynchronous to i_clk.
// Notes on behaviour
// - Vbus level change sets bit 15
// - Vbus and resume flags set while clock halted
// - Zero-write clears those only with clock running
// - J to K/SE0 sets resume if enabled
// - Start-of-frame sets bit 13
// - Writable flags: one keeps, zero clears
// - Four maskable causes set device-state flag
// - Five causes set control-stage flag
// - Empty flag mirrors enabled endpoint empty bits
// - Nack flag mirrors enabled endpoint not-ready bits
// - Ready flag mirrors enabled endpoint ready bits
// - Bit 7 shows sampled Vbus level
// - Device-state field encodes USB device states
// - USB reset loads default, suspend loads suspended
// - SetAddress/SetConfiguration advance device state
// - Fields writable only in software control mode
// - Setup flag sets, never interrupts
// - Control-stage field encodes transfer stage
// - Fields and flags reset as documented
// - Causes gated by enable register zero bits, except setup end
// - Per-endpoint enable bits for buffer interrupts
module udis_status
  import udis_pkg::*;
#(
  parameter int NUM_EP = UDIS_NUM_EP
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_running,
  input wire logic i_sw_reset,
  input wire logic i_sw_ctrl_mode,
  input wire logic i_vbus,
  input wire logic i_line_j,
  input wire logic i_line_k_or_se0,
  input wire udis_events_s i_ev,
  input wire udis_enables_s i_en,
  input wire logic [NUM_EP-1:0] i_ep_ready_bits,
  input wire logic [NUM_EP-1:0] i_ep_not_ready_bits,
  input wire logic [NUM_EP-1:0] i_ep_empty_overflow_bits,
  input wire logic [NUM_EP-1:0] i_ep_ready_ie,
  input wire logic [NUM_EP-1:0] i_ep_not_ready_ie,
  input wire logic [NUM_EP-1:0] i_ep_empty_ie,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_meta_q, rst_sync_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  logic [2:0] pin_meta_q, pin_sync_q, pin_prev_q;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_prev_q <= 3'h0;
    end else begin
      pin_meta_q <= {i_vbus, i_line_j, i_line_k_or_se0};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  logic vbus_s, vbus_prev, j_prev, kse0_s;
  assign vbus_s = pin_sync_q[2];
  assign vbus_prev = pin_prev_q[2];
  assign j_prev = pin_prev_q[1];
  assign kse0_s = pin_sync_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Status state
  function automatic logic clr_bit(input logic [15:0] d, input int b);
    return i_wr && (i_addr == UDIS_ADDR_STATUS_MAIN) && !d[b];
  endfunction

  logic vbus_chg_q, vbus_chg_d, resume_q, resume_d, frame_q, frame_d;
  logic dchg_q, dchg_d, cchg_q, cchg_d, setup_q, setup_d, vlvl_q, vlvl_d;
  logic [2:0] ds_q, ds_d, cs_q, cs_d;
  logic empty_f, nack_f, ready_f;
  logic hit_wr, hw_clr, dev_cause, ctl_cause;

  // The halted-clock case: this block keeps running on i_clk, the
  // internal clock gate state is reported through i_clk_running.
  assign hit_wr = i_wr && (i_addr == UDIS_ADDR_STATUS_MAIN);
  assign hw_clr = i_clk_running;
  assign dev_cause = (i_ev.usb_reset && i_en.en_usb_reset)
                   | (i_ev.suspend && i_en.en_suspend)
                   | (i_ev.set_address_done && i_en.en_set_address)
                   | (i_ev.set_config_done
                      && i_en.en_set_config);
  assign ctl_cause = i_ev.setup_end
                   | (i_ev.wr_status_entry && i_en.en_wr_status)
                   | (i_ev.rd_status_entry && i_en.en_rd_status)
                   | (i_ev.xfer_complete && i_en.en_complete)
                   | (i_ev.seq_error && i_en.en_seq_error);
  assign empty_f = |(i_ep_empty_overflow_bits & i_ep_empty_ie);
  assign nack_f = |(i_ep_not_ready_bits & i_ep_not_ready_ie);
  assign ready_f = |(i_ep_ready_bits & i_ep_ready_ie);

  always_comb begin
    // Set wins over clear for every flag
    vbus_chg_d = (vbus_s != vbus_prev)
               | (vbus_chg_q && !(clr_bit(i_wdata, UDIS_BIT_VBUS_CHG)
                                  && hw_clr));
    resume_d = (j_prev && kse0_s && i_en.resume_irq_enable)
             | (resume_q && !(clr_bit(i_wdata, UDIS_BIT_RESUME)
                              && hw_clr));
    frame_d = i_ev.frame_start
            | (frame_q && !clr_bit(i_wdata, UDIS_BIT_FRAME));
    dchg_d = dev_cause | (dchg_q && !clr_bit(i_wdata, UDIS_BIT_DSTATE));
    cchg_d = ctl_cause | (cchg_q && !clr_bit(i_wdata, UDIS_BIT_CSTAGE));
    setup_d = i_ev.setup_rx
            | (setup_q && !clr_bit(i_wdata, UDIS_BIT_SETUP));
    vlvl_d = vbus_s;
    ds_d = ds_q;
    cs_d = cs_q;
    if (hit_wr && i_sw_ctrl_mode) begin
      ds_d = i_wdata[UDIS_DS_LSB +: UDIS_FIELD_W];
      cs_d = i_wdata[UDIS_CS_LSB +: UDIS_FIELD_W];
    end
    if (i_ev.stage_load) cs_d = i_ev.stage_code;
    if (i_ev.set_address_done) ds_d = UDIS_DS_ADDRESS;
    if (i_ev.set_config_done) ds_d = UDIS_DS_CONFIGURED;
    if (i_ev.suspend) ds_d = UDIS_DS_SUSPENDED;
    if (i_ev.usb_reset) ds_d = UDIS_DS_DEFAULT;
    if (i_sw_reset) begin
      ds_d = UDIS_DS_POWERED;
      cs_d = 3'h0;
      {vbus_chg_d, resume_d, frame_d, dchg_d, cchg_d, setup_d} = 6'h00;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      {vbus_chg_q, resume_q, frame_q, dchg_q, cchg_q, setup_q} <= 6'h00;
      vlvl_q <= 1'b0;
      ds_q <= UDIS_DS_POWERED;
      cs_q <= 3'h0;
    end else begin
      {vbus_chg_q, resume_q, frame_q, dchg_q, cchg_q, setup_q}
        <= {vbus_chg_d, resume_d, frame_d, dchg_d, cchg_d, setup_d};
      vlvl_q <= vlvl_d;
      ds_q <= ds_d;
      cs_q <= cs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and interrupt request, both registered
  logic [15:0] word, rdata_d;
  logic irq_d;
  always_comb begin
    word = UDIS_RESET_VALUE;
    word[UDIS_BIT_VBUS_CHG] = vbus_chg_q;
    word[UDIS_BIT_RESUME] = resume_q;
    word[UDIS_BIT_FRAME] = frame_q;
    word[UDIS_BIT_DSTATE] = dchg_q;
    word[UDIS_BIT_CSTAGE] = cchg_q;
    word[UDIS_BIT_EMPTY] = empty_f;
    word[UDIS_BIT_NACK] = nack_f;
    word[UDIS_BIT_READY] = ready_f;
    word[UDIS_BIT_VBUS_LVL] = vlvl_q;
    word[UDIS_DS_LSB +: UDIS_FIELD_W] = ds_q;
    word[UDIS_BIT_SETUP] = setup_q;
    word[UDIS_CS_LSB +: UDIS_FIELD_W] = cs_q;
    rdata_d = (i_rd && i_addr == UDIS_ADDR_STATUS_MAIN) ? word : 16'h0000;
    // Setup flag deliberately left out
    irq_d = (vbus_chg_q && i_en.vbus_ie) | (resume_q && i_en.resume_irq_enable)
          | (frame_q && i_en.frame_ie) | (dchg_q && i_en.dstate_ie)
          | (cchg_q && i_en.cstage_ie) | (empty_f && i_en.empty_ie)
          | (nack_f && i_en.nack_ie) | (ready_f && i_en.ready_ie);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 16'h0000;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Own read decode, so the read checks do not lean on rdata_d
  logic rd_hit;
  assign rd_hit = i_rd && (i_addr == UDIS_ADDR_STATUS_MAIN);

  AST_VBUS_EDGE: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (vbus_s != vbus_prev && !i_sw_reset) |=> vbus_chg_q)
    else $error("vbus change did not set flag");
  AST_HALT_HOLD: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (vbus_chg_q && !i_clk_running && !i_sw_reset) |=> vbus_chg_q)
    else $error("vbus flag cleared while clock halted");
  AST_RESUME_GATE: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (!resume_q && !i_en.resume_irq_enable) |=> !resume_q)
    else $error("resume flag set while disabled");
  AST_RESUME_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (j_prev && kse0_s && i_en.resume_irq_enable && !i_sw_reset)
      |=> resume_q)
    else $error("enabled line change did not set resume flag");
  AST_FRAME_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.frame_start && !i_sw_reset) |=> frame_q)
    else $error("frame start lost");
  AST_KEEP_ONE: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (hit_wr && i_wdata[UDIS_BIT_FRAME] && frame_q && !i_sw_reset)
      |=> frame_q)
    else $error("writing one cleared frame flag");
  AST_ZERO_CLEAR: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (hit_wr && !i_wdata[UDIS_BIT_FRAME] && !i_ev.frame_start
      && !i_sw_reset) |=> !frame_q)
    else $error("writing zero did not clear frame flag");
  AST_DSTATE_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.set_address_done && i_en.en_set_address && !i_sw_reset)
      |=> dchg_q)
    else $error("enabled address cause did not set state flag");
  AST_STAGE_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.setup_end && !i_sw_reset) |=> cchg_q)
    else $error("setup end did not set stage flag");
  AST_STAGE_MASK: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (!cchg_q && !i_ev.setup_end && !i_en.en_wr_status
      && !i_en.en_rd_status && !i_en.en_complete && !i_en.en_seq_error)
      |=> !cchg_q)
    else $error("masked stage cause set stage flag");
  AST_EMPTY_MIRROR: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    rd_hit |=> o_rdata[UDIS_BIT_EMPTY] == $past(empty_f))
    else $error("empty flag not mirrored");
  AST_EMPTY_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (rd_hit && |(i_ep_empty_overflow_bits & i_ep_empty_ie))
      |=> o_rdata[UDIS_BIT_EMPTY])
    else $error("enabled empty endpoint not reported");
  AST_NACK_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (rd_hit && |(i_ep_not_ready_bits & i_ep_not_ready_ie))
      |=> o_rdata[UDIS_BIT_NACK])
    else $error("enabled not-ready endpoint not reported");
  AST_READY_CLR: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (rd_hit && (i_ep_ready_bits & i_ep_ready_ie) == '0)
      |=> !o_rdata[UDIS_BIT_READY])
    else $error("ready flag reported with no ready endpoint");
  AST_VBUS_LEVEL: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    $rose(vbus_s) |=> vlvl_q)
    else $error("vbus level bit did not follow pin");
  AST_DEV_RESET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.usb_reset && !i_sw_reset) |=> ds_q == UDIS_DS_DEFAULT)
    else $error("usb reset did not load default state");
  AST_DS_SUSPEND: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.suspend && !i_ev.usb_reset && !i_sw_reset)
      |=> ds_q[UDIS_FIELD_W-1])
    else $error("suspend did not load a suspended code");
  AST_DS_CONFIG: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.set_config_done && !i_ev.suspend && !i_ev.usb_reset
      && !i_sw_reset) |=> ds_q == UDIS_DS_CONFIGURED)
    else $error("configuration did not load configured state");
  AST_FIELD_LOCK: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (!i_sw_ctrl_mode && !i_ev.stage_load && !i_sw_reset)
      |=> $stable(cs_q))
    else $error("stage field changed outside software mode");
  AST_DS_LOCK: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (!i_sw_ctrl_mode && !i_ev.set_address_done && !i_ev.set_config_done
      && !i_ev.suspend && !i_ev.usb_reset && !i_sw_reset) |=> $stable(ds_q))
    else $error("state field changed outside software mode");
  AST_SETUP_SET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.setup_rx && !i_sw_reset) |=> setup_q)
    else $error("setup packet did not set setup flag");
  AST_STAGE_LOAD: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (i_ev.stage_load && !i_sw_reset) |=> cs_q == $past(i_ev.stage_code))
    else $error("stage code not loaded");
  AST_SW_RESET: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_sw_reset |=> (ds_q == UDIS_DS_POWERED && cs_q == '0
      && !vbus_chg_q && !resume_q && !frame_q && !setup_q))
    else $error("software reset left state behind");
  AST_SETUP_NO_IRQ: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (word[15:8] == 8'h00) |=> !o_irq)
    else $error("irq without event flag");
  AST_IRQ_ENABLED: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    (frame_q && i_en.frame_ie) |=> o_irq)
    else $error("enabled flag did not raise irq");
  COV_VBUS: cover property (@(posedge i_clk) disable iff (!rst_n) vbus_chg_q);
  COV_RESUME: cover property (@(posedge i_clk) disable iff (!rst_n) resume_q);
  COV_IRQ: cover property (@(posedge i_clk) disable iff (!rst_n) o_irq);
  COV_CONFIG: cover property (@(posedge i_clk) disable iff (!rst_n)
    ds_q == UDIS_DS_CONFIGURED);
  COV_STAGE_ERR: cover property (@(posedge i_clk) disable iff (!rst_n)
    cs_q == UDIS_CS_SEQ_ERR);
endmodule

/* File: tb/udis_cpu_model.sv */
// Host CPU model driving the status block's register bus.
// Assumes requests launched on the falling edge of the bench clock.
module udis_cpu_model
  import udis_pkg::*;
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  // Request held across one rising edge, answer taken a cycle later
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    @(negedge i_clk);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
  endtask
  // Zero only on handled flags, ones elsewhere
  task automatic clear_flags(input logic [15:0] bits);
    logic [15:0] q;
    access(1'b1, UDIS_ADDR_STATUS_MAIN, ~bits, q);
  endtask
endmodule

/* File: tb/usb_device_interrupt_status_test.sv */
// Self-checking bench for the USB device interrupt status block.
// Assumes udis_pkg, the status block and the CPU model are compiled.
module usb_device_interrupt_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  import udis_pkg::*;
  localparam logic [2:0] DSV [4] = '{3'h3, 3'h2, 3'h4, 3'h1};
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b1, swr = 1'b0, swm = 1'b0;
  logic vbus = 1'b0, lj = 1'b1, lk = 1'b0, wr, rd, irq;
  udis_events_s ev = '0;
  udis_enables_s en = '1;
  logic [5:0] rb = '0, nb = '0, eb = '0, rie = '0, nie = '0, eie = '0;
  logic [7:0] addr;
  logic [15:0] wd, rdata, q, m;
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'ha208;
  always #50 clk = ~clk;
  udis_status udis_status_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_clk_running(run), .i_sw_reset(swr), .i_sw_ctrl_mode(swm),
    .i_vbus(vbus), .i_line_j(lj), .i_line_k_or_se0(lk), .i_ev(ev),
    .i_en(en), .i_ep_ready_bits(rb), .i_ep_not_ready_bits(nb),
    .i_ep_empty_overflow_bits(eb), .i_ep_ready_ie(rie),
    .i_ep_not_ready_ie(nie), .i_ep_empty_ie(eie), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rdata), .o_irq(irq));
  udis_cpu_model cpu_i (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Buffer summaries are derived live from the endpoint levels
  function automatic logic [15:0] ew();
    ew = m;
    ew[10] = |(eb & eie);
    ew[9] = |(nb & nie);
    ew[8] = |(rb & rie);
  endfunction
  task automatic rdchk();
    logic [15:0] w;
    w = ew();
    cpu_i.access(1'b0, UDIS_ADDR_STATUS_MAIN, 16'h0000, q);
    chk(q, w);
    chk({15'h0, irq}, {15'h0, |(w[15:8] & en[15:8])});
  endtask
  task automatic pins(input logic v, input logic j, input logic k);
    @(negedge clk);
    vbus = v;
    lj = j;
    lk = k;
    repeat (5) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    m = 16'h0000;
    rdchk();
    $display("reset test done");
    run = 1'b0;
    pins(1'b1, 1'b1, 1'b0);
    m[15] = 1'b1;
    m[7] = 1'b1;
    rdchk();
    cpu_i.clear_flags(16'h8000);
    rdchk();
    run = 1'b1;
    cpu_i.clear_flags(16'h8000);
    m[15] = 1'b0;
    rdchk();
    pins(1'b0, 1'b1, 1'b0);
    m[15:7] = 9'h100;
    rdchk();
    cpu_i.clear_flags(16'h8000);
    en.resume_irq_enable = 1'b0;
    pins(1'b0, 1'b0, 1'b1);
    m[15] = 1'b0;
    rdchk();
    pins(1'b0, 1'b1, 1'b0);
    en.resume_irq_enable = 1'b1;
    pins(1'b0, 1'b0, 1'b1);
    m[14] = 1'b1;
    rdchk();
    cpu_i.clear_flags(16'h4000);
    m[14] = 1'b0;
    $display("pin test done");
    for (int i = 4; i < 15; i++) begin
      for (int k = 0; k < 2; k++) begin
        en[7:0] = k ? 8'hFF : 8'h00;
        @(negedge clk);
        ev = udis_events_s'(15'h0001 << i);
        @(negedge clk);
        ev = '0;
        if (i >= 11) begin
          if (k) m[12] = 1'b1;
          m[6:4] = DSV[i-11];
        end else if (i >= 6) begin
          if (k || i == 10) m[11] = 1'b1;
        end else m[i == 5 ? 13 : 3] = 1'b1;
        rdchk();
        cpu_i.clear_flags(16'hF808);
        m[15:11] = 5'h00;
        m[3] = 1'b0;
      end
    end
    $display("event test done");
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {rb, nb, eb} = 18'($random(seed));
      {rie, nie, eie} = 18'($random(seed));
      repeat (2) @(negedge clk);
      rdchk();
    end
    $display("endpoint test done");
    swm = 1'b1;
    for (int c = 0; c < 7; c++) begin
      cpu_i.access(1'b1, UDIS_ADDR_STATUS_MAIN,
                   {9'h1FF, 3'(c), 1'b1, 3'(c)}, q);
      m[6:4] = 3'(c);
      m[2:0] = 3'(c);
      rdchk();
    end
    swm = 1'b0;
    cpu_i.access(1'b1, UDIS_ADDR_STATUS_MAIN, 16'hFF88, q);
    rdchk();
    @(negedge clk);
    ev.stage_load = 1'b1;
    ev.stage_code = 3'h2;
    @(negedge clk);
    ev = '0;
    m[2:0] = 3'h2;
    rdchk();
    @(negedge clk);
    swr = 1'b1;
    @(negedge clk);
    swr = 1'b0;
    m = m & 16'h0080;
    rdchk();
    $display("field test done");
    end_of_test();
  end
endmodule
